// ===== serial_rx_flow.v
// serial receiver with substitute on error, input buffer, busy line and xon/xoff flow control
//
// Notes on behaviour
// - eight bit rates, 150 to 19200, shared.
// - start bit, then seven or eight data.
// - parity none, odd or even, checked.
// - at least one mark stop bit.
// - half-bit recheck; false start resumes hunting.
// - sample bits one bit time apart.
// - lsb first, parity after last data.
// - space at stop sample is framing error.
// - parity mismatch flags parity error.
// - erroneous characters stored as question mark; dropped when buffer full.
// - character during busy: overrun, stored as question mark; dropped when buffer full.
// - keep receiving while printing drains buffer.
// - busy at power-on, self-test, transition, reset.
// - send xoff at low free space.
// - send xon above high free space.
// - handshake mode: status waits dsr space.
// - otherwise status ignores dsr.
// - handshake mode: dtr space ready, mark busy.
// - buffer size switch picks depth, thresholds.
`include "serial_rx_map.vh"
module serial_rx_flow #(
    parameter BASE_DIV = `BASE_DIV_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire rxd,
    input wire dsr,
    output reg txd,
    output reg dtr,
    input wire self_test,
    input wire online_transition,
    output reg [7:0] out_data,
    output reg out_valid,
    input wire out_ready
);
    localparam RX_HUNT = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_BITS = 2'd2;
    localparam RX_STOP = 2'd3;

    // settings: serial_format_switches, bit_rate_switches, buffer_size_switch
    reg [16:0] ctrl;
    wire len7 = ctrl[`CTRL_LEN7];
    wire par_en = ctrl[`CTRL_PAR_EN];
    wire par_even = ctrl[`CTRL_PAR_EVEN];
    wire xon_mode = ctrl[`CTRL_XON_MODE];
    wire [2:0] bit_rate_switches = ctrl[`CTRL_RATE_LO+2:`CTRL_RATE_LO];
    wire buffer_size_switch = ctrl[`CTRL_BUF_4K];
    wire rx_enable = ctrl[`CTRL_RX_ENABLE];

    // bus holding registers
    reg aw_got;
    reg w_got;
    reg [3:0] wr_addr;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;
    wire do_write = aw_got && w_got && !s_axi_bvalid;

    // sticky error flags, framing / parity / overrun
    reg [2:0] err_flags;

    // receiver state
    reg [1:0] rx_state;
    reg [3:0] rx_cnt;
    reg [3:0] rx_bitn;
    reg [8:0] rx_bits;
    reg rx_prev;
    reg rx_late;
    reg rx_push;
    reg [7:0] rx_char;
    reg [2:0] rx_err;

    // buffer and flow state
    reg [7:0] mem [0:4095];
    reg [11:0] wr_ptr;
    reg [11:0] rd_ptr;
    reg [12:0] count;
    reg hold_flow;
    reg xoff_sent;

    // transmitter state
    reg [11:0] tx_sh;
    reg [3:0] tx_left;
    reg [3:0] tx_cnt;
    reg stat_pending;
    reg [7:0] stat_byte;

    // baud divider
    reg [14:0] div_cnt;
    reg tick;

    // parity bit that makes the chosen sense true
    function par_of;
        input [7:0] d;
        input even;
        begin
            par_of = (^d) ^ ~even;
        end
    endfunction

    // whole frame, start bit in bit 0, mark filled above stop
    function [11:0] frame_of;
        input [7:0] d;
        input l7;
        input pen;
        input even;
        reg [7:0] dm;
        begin
            dm = l7 ? {1'b0, d[6:0]} : d;
            frame_of = 12'hfff;
            frame_of[0] = 1'b0;
            if (l7) begin
                frame_of[7:1] = dm[6:0];
                if (pen) begin
                    frame_of[8] = par_of(dm, even);
                end
            end else begin
                frame_of[8:1] = dm;
                if (pen) begin
                    frame_of[9] = par_of(dm, even);
                end
            end
        end
    endfunction

    // byte-lane merge for writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // depth and thresholds follow the buffer size switch
    // depth selection
    wire [12:0] depth = buffer_size_switch ? `LARGE_DEPTH : `SMALL_DEPTH;
    wire [12:0] low_mark = buffer_size_switch ? `LARGE_LOW : `SMALL_LOW;
    wire [12:0] high_mark = buffer_size_switch ? `LARGE_HIGH : `SMALL_HIGH;
    // count above depth after shrinking the switch reads as zero room
    wire [12:0] free = (count >= depth) ? 13'h0000 : depth - count;
    wire full = (free == 13'h0000);
    // busy covers flow hold and every not-ready condition
    // busy sources
    wire busy = hold_flow || !rx_enable || self_test || online_transition;

    // 16x baud enable; divisor halves per rate step
    // baud enable
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 15'h0000;
            tick <= 1'b0;
        end else if (div_cnt == 15'h0000) begin
            div_cnt <= BASE_DIV[14:0] >> bit_rate_switches;
            tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt - 15'h0001;
            tick <= 1'b0;
        end
    end

    // receiver: hunt, half-bit check, data bits, stop
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_state <= RX_HUNT;
            rx_cnt <= 4'h0;
            rx_bitn <= 4'h0;
            rx_bits <= 9'h000;
            rx_prev <= 1'b1;
            rx_late <= 1'b0;
            rx_push <= 1'b0;
            rx_char <= 8'h00;
            rx_err <= 3'h0;
        end else begin
            rx_push <= 1'b0;
            if (tick) begin
                rx_prev <= rxd;
                case (rx_state)
                    RX_HUNT: begin
                        // only a real mark-to-space edge starts a character
                        if (rx_prev && !rxd) begin
                            rx_state <= RX_START;
                            rx_cnt <= 4'h0;
                        end
                    end
                    RX_START: begin
                        if (rx_cnt == `OS_HALF) begin
                            if (!rxd) begin
                                rx_state <= RX_BITS;
                                rx_cnt <= 4'h0;
                                rx_bitn <= 4'h0;
                                rx_late <= busy;
                            end else begin
                                rx_state <= RX_HUNT;
                            end
                        end else begin
                            rx_cnt <= rx_cnt + 4'h1;
                        end
                    end
                    RX_BITS: begin
                        if (rx_cnt == `OS_LAST) begin
                            rx_bits[rx_bitn] <= rxd;
                            rx_cnt <= 4'h0;
                            if (rx_bitn == (len7 ? 4'h6 : 4'h7) + {3'h0, par_en}) begin
                                rx_state <= RX_STOP;
                            end else begin
                                rx_bitn <= rx_bitn + 4'h1;
                            end
                        end else begin
                            rx_cnt <= rx_cnt + 4'h1;
                        end
                    end
                    RX_STOP: begin
                        if (rx_cnt == `OS_LAST) begin
                            rx_state <= RX_HUNT;
                            rx_push <= 1'b1;
                            rx_err[`ST_FRAMING] <= !rxd;
                            rx_err[`ST_PARITY] <= par_en && (len7 ?
                                (rx_bits[7] != par_of({1'b0, rx_bits[6:0]}, par_even)) :
                                (rx_bits[8] != par_of(rx_bits[7:0], par_even)));
                            rx_err[`ST_OVERRUN] <= rx_late;
                            rx_char <= len7 ? {1'b0, rx_bits[6:0]} : rx_bits[7:0];
                        end else begin
                            rx_cnt <= rx_cnt + 4'h1;
                        end
                    end
                    default: begin
                        rx_state <= RX_HUNT;
                    end
                endcase
            end
        end
    end

    // buffer write and drain toward the print side
    wire push = rx_push && !full;
    wire pop = (!out_valid || out_ready) && (count != 13'h0000);
    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= 12'h000;
            rd_ptr <= 12'h000;
            count <= 13'h0000;
            out_valid <= 1'b0;
            out_data <= 8'h00;
        end else begin
            if (push) begin
                mem[wr_ptr] <= (rx_err != 3'h0) ? `SUBST_CHAR : rx_char;
                wr_ptr <= wr_ptr + 12'h001;
            end
            if (pop) begin
                out_data <= mem[rd_ptr];
                out_valid <= 1'b1;
                rd_ptr <= rd_ptr + 12'h001;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            count <= count + {12'h000, push} - {12'h000, pop};
        end
    end

    // flow hold with hysteresis; busy line registered
    always @(posedge aclk) begin
        if (!aresetn) begin
            hold_flow <= 1'b0;
            dtr <= 1'b1;
        end else begin
            if (free <= low_mark) begin
                hold_flow <= 1'b1;
            end else if (free > high_mark) begin
                hold_flow <= 1'b0;
            end
            dtr <= busy;
        end
    end

    // transmitter: xon/xoff first, then one status byte
    wire flow_due = xon_mode && (hold_flow != xoff_sent);
    wire stat_ok = stat_pending && (xon_mode || !dsr);
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_sh <= 12'hfff;
            tx_left <= 4'h0;
            tx_cnt <= 4'h0;
            txd <= 1'b1;
            xoff_sent <= 1'b0;
            stat_pending <= 1'b0;
            stat_byte <= 8'h00;
        end else begin
            if (!xon_mode) begin
                xoff_sent <= 1'b0;
            end
            // a second status byte while one waits is dropped
            if (do_write && wr_addr == `REG_TXDATA && !stat_pending && wr_strb[0]) begin
                stat_pending <= 1'b1;
                stat_byte <= wr_data[7:0];
            end
            if (tick) begin
                if (tx_left == 4'h0) begin
                    if (flow_due) begin
                        tx_sh <= frame_of(hold_flow ? `XOFF_CHAR : `XON_CHAR,
                            len7, par_en, par_even);
                        xoff_sent <= hold_flow;
                        tx_left <= (len7 ? 4'h9 : 4'ha) + {3'h0, par_en};
                        tx_cnt <= 4'h0;
                        txd <= 1'b0;
                    end else if (stat_ok) begin
                        tx_sh <= frame_of(stat_byte, len7, par_en, par_even);
                        stat_pending <= 1'b0;
                        tx_left <= (len7 ? 4'h9 : 4'ha) + {3'h0, par_en};
                        tx_cnt <= 4'h0;
                        txd <= 1'b0;
                    end
                end else if (tx_cnt == `OS_LAST) begin
                    tx_sh <= {1'b1, tx_sh[11:1]};
                    txd <= (tx_left == 4'h1) ? 1'b1 : tx_sh[1];
                    tx_left <= tx_left - 4'h1;
                    tx_cnt <= 4'h0;
                end else begin
                    tx_cnt <= tx_cnt + 4'h1;
                end
            end
        end
    end

    // sticky error flags; a new event beats a clear
    wire [2:0] err_set = rx_push ? (rx_err | {full, 2'b00}) : 3'h0;
    wire [2:0] err_clr = (do_write && wr_addr == `REG_STATUS && wr_strb[0]) ?
        wr_data[2:0] : 3'h0;
    always @(posedge aclk) begin
        if (!aresetn) begin
            err_flags <= 3'h0;
        end else begin
            err_flags <= (err_flags & ~err_clr) | err_set;
        end
    end

    // control register with byte lanes
    wire [31:0] ctrl_merged = merge({15'h0000, ctrl}, wr_data, wr_strb);
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `CTRL_RESET;
        end else if (do_write && wr_addr == `REG_CTRL) begin
            ctrl <= ctrl_merged[16:0];
        end
    end

    // write channel: either order, response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                wr_addr <= {s_axi_awaddr[3:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                // every word decodes; only reserved space would err
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                aw_got <= 1'b0;
                w_got <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel: data one cycle after address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'b00})
                `REG_CTRL: begin
                    s_axi_rdata <= {15'h0000, ctrl};
                end
                `REG_STATUS: begin
                    s_axi_rdata <= {3'h0, count, 10'h000, tx_left != 4'h0,
                        xoff_sent, busy, err_flags};
                end
                `REG_TXDATA: begin
                    s_axi_rdata <= {23'h000000, stat_pending, stat_byte};
                end
                `REG_FREE: begin
                    s_axi_rdata <= {19'h00000, free};
                end
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RESP_DECERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// ===== serial_rx_map.vh
// register offsets, field positions, reset values and timing counts of the serial receiver
`ifndef SERIAL_RX_MAP_VH
`define SERIAL_RX_MAP_VH
`define CLK_HZ 40000000
`define BASE_BAUD 150
`define OVERSAMPLE 16
`define BASE_DIV_CYCLES (`CLK_HZ / (`BASE_BAUD * `OVERSAMPLE))
`define OS_LAST 4'hf
`define OS_HALF 4'h7
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_TXDATA 4'h8
`define REG_FREE 4'hc
`define CTRL_LEN7 0
`define CTRL_PAR_EN 1
`define CTRL_PAR_EVEN 2
`define CTRL_XON_MODE 3
`define CTRL_RATE_LO 4
`define CTRL_BUF_4K 8
`define CTRL_RX_ENABLE 16
`define CTRL_RESET 17'h00000
`define ST_FRAMING 0
`define ST_PARITY 1
`define ST_OVERRUN 2
`define ST_BUSY 3
`define ST_XOFF 4
`define ST_TX_BUSY 5
`define ST_COUNT_LO 16
`define SMALL_DEPTH 13'h0048
`define LARGE_DEPTH 13'h1000
`define SMALL_LOW 13'h000a
`define SMALL_HIGH 13'h0014
`define LARGE_LOW 13'h0080
`define LARGE_HIGH 13'h0100
`define SUBST_CHAR 8'h3f
`define XON_CHAR 8'h11
`define XOFF_CHAR 8'h13
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ===== serial_rx_flow_props.sv
// port timing checker for the serial receiver with flow control
module serial_rx_flow_props #(
    parameter BASE_DIV = 16666
) (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire rxd,
    input wire dsr,
    input wire txd,
    input wire dtr,
    input wire self_test,
    input wire online_transition,
    input wire [7:0] out_data,
    input wire out_valid,
    input wire out_ready
);
    // one clock domain, checks idle while reset is held
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_idle_after_reset: assert property (
        $rose(aresetn) |-> txd && dtr && !out_valid) else $error("line not idle after reset");
    a_busy_selftest: assert property (
        self_test [*3] |-> dtr) else $error("busy missing in self test");
    a_busy_online: assert property (
        online_transition [*3] |-> dtr) else $error("busy missing in online transition");
    a_out_held: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("out data dropped");
    a_tx_start_len: assert property (
        $fell(txd) |-> (!txd) [*8]) else $error("start bit on txd too short");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    a_rdata_held: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_bresp_okay: assert property (
        s_axi_bvalid |-> s_axi_bresp == 2'h0 && s_axi_rresp == 2'h0) else $error("bad response");
endmodule

bind serial_rx_flow serial_rx_flow_props #(.BASE_DIV(BASE_DIV)) i_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rxd(rxd), .dsr(dsr), .txd(txd), .dtr(dtr),
    .self_test(self_test), .online_transition(online_transition), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready));

// ===== serial_host_model.sv
// host serial port model: sends framed characters and decodes the printer's replies
module serial_host_model (
    input wire logic aclk,
    input wire logic dtr,
    input wire logic txd,
    input wire logic xon_mode,
    input wire logic [15:0] bit_cyc,
    output logic rxd,
    output logic [7:0] got,
    output int n_got
);
    logic stopped; // set by xoff, cleared by xon
    initial begin
        rxd = 1'b1;
        stopped = 1'b0;
        got = 8'h00;
        n_got = 0;
    end
    // one bit held for a full bit time, rate shared
    task automatic bit_out(input logic b);
        rxd <= b;
        repeat (bit_cyc) @(posedge aclk);
    endtask
    // framing, lsb first, flow control waits
    task automatic send(input logic [7:0] d, input logic l7, pen, even, bad_par, bad_stop,
                        input logic force_it);
        logic p;
        p = (l7 ? ^d[6:0] : ^d) ^ ~even ^ bad_par;
        while (!force_it && (xon_mode ? stopped : dtr)) @(posedge aclk);
        @(posedge aclk);
        bit_out(1'b0);
        for (int i = 0; i < (l7 ? 7 : 8); i++) bit_out(d[i]);
        if (pen) bit_out(p);
        bit_out(~bad_stop);
        // a broken stop bit is followed by mark again
        if (bad_stop) bit_out(1'b1);
    endtask
    // short space pulse, too short to pass the half-bit recheck
    task automatic glitch;
        @(posedge aclk);
        rxd <= 1'b0;
        repeat (bit_cyc / 4) @(posedge aclk);
        rxd <= 1'b1;
    endtask
    // decode replies on txd, eight data bits, sampled mid-bit
    initial forever begin
        @(posedge aclk);
        if (txd === 1'b0) begin
            repeat (bit_cyc / 2) @(posedge aclk);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_cyc) @(posedge aclk);
                got[i] = txd;
            end
            repeat (bit_cyc) @(posedge aclk);
            n_got++;
            // host pauses on xoff until xon
            if (got == 8'h13) stopped = 1'b1;
            if (got == 8'h11) stopped = 1'b0;
        end
    end
endmodule

// ===== serial_rx_flow_tb.sv
// self-checking bench for the serial receiver with flow control
module serial_rx_flow_tb;
timeunit 1ns;
timeprecision 1ps;
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dsr, self_test, online, oready;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, v;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, rxd, txd, dtr, ovalid, xon;
    logic [31:0] rdata;
    logic [7:0] odata, got;
    logic [15:0] bit_cyc; // aclk cycles per bit at the chosen rate
    int n_got, error_cnt = 0, n_tests = 0;
    localparam logic [31:0] EN = 32'h10000; // receiver ready bit
    serial_rx_flow #(.BASE_DIV(16)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rxd(rxd), .dsr(dsr), .txd(txd), .dtr(dtr), .self_test(self_test),
        .online_transition(online), .out_data(odata), .out_valid(ovalid), .out_ready(oready));
    serial_host_model i_host (.aclk(aclk), .dtr(dtr), .txd(txd), .xon_mode(xon),
        .bit_cyc(bit_cyc), .rxd(rxd), .got(got), .n_got(n_got));
    // free-running device clock, 40 MHz
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // register write: address and data offered together, released as taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    // register read, data taken at the edge where rvalid is seen
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rready <= 1'b0;
    endtask
    // control word and matching bit time for the host model
    task automatic cfg(input logic [31:0] c);
        wr(4'h0, c);
        bit_cyc = 16'd16 * ((16'd16 >> c[6:4]) + 16'd1);
        xon = c[3];
        repeat (4) @(posedge aclk);
    endtask
    // wait for a buffered character, compare and hand it on
    task automatic take(input logic [7:0] e);
        // skip the edge of the last pop
        @(posedge aclk);
        for (int t = 0; t < 4000 && ovalid !== 1'b1; t++) @(posedge aclk);
        `CHK("out_data", {1'b1, e}, {ovalid, odata})
        oready <= 1'b1;
        @(posedge aclk);
        oready <= 1'b0;
    endtask
    // wait for one more reply byte on txd
    task automatic waittx(input int k);
        for (int t = 0; t < bit_cyc * 30 && n_got == k; t++) @(posedge aclk);
        `CHK("tx_count", k + 1, n_got)
    endtask
    task automatic t_reset;
        `CHK("txd", 1'b1, txd)
        `CHK("dtr", 1'b1, dtr)
        rd(4'h0, v);
        `CHK("ctrl_reset", 32'h0, v)
        rd(4'hc, v);
        `CHK("free_small", 13'd72, v[12:0])
    endtask
    task automatic t_rates;
        for (int r = 0; r < 3; r++) begin
            cfg(EN | (r << 4));
            `CHK("dtr_ready", 1'b0, dtr)
            i_host.send(8'ha5 ^ r[7:0], 0, 0, 0, 0, 0, 0);
            take(8'ha5 ^ r[7:0]);
        end
    endtask
    task automatic t_parity;
        for (int e = 0; e < 2; e++) begin
            cfg(EN | 32'h23 | (e << 2));
            i_host.send(8'hb5, 1, 1, e[0], 0, 0, 0);
            take(8'h35);
            i_host.send(8'h35, 1, 1, e[0], 1, 0, 0);
            take(8'h3f);
            rd(4'h4, v);
            `CHK("parity_flag", 1'b1, v[1])
            wr(4'h4, 32'h2);
        end
    endtask
    task automatic t_frame;
        cfg(EN | 32'h20);
        i_host.send(8'h5a, 0, 0, 0, 0, 1, 0);
        take(8'h3f);
        rd(4'h4, v);
        `CHK("framing_flag", 3'h1, v[2:0])
        wr(4'h4, 32'h1);
        i_host.glitch;
        repeat (bit_cyc * 12) @(posedge aclk);
        `CHK("false_start", 1'b0, ovalid)
        rd(4'h4, v);
        `CHK("false_flags", 3'h0, v[2:0])
        i_host.send(8'hc3, 0, 0, 0, 0, 0, 0);
        take(8'hc3);
    endtask
    task automatic t_busy;
        self_test <= 1'b1;
        repeat (4) @(posedge aclk);
        `CHK("dtr_test", 1'b1, dtr)
        i_host.send(8'h41, 0, 0, 0, 0, 0, 1);
        take(8'h3f);
        rd(4'h4, v);
        `CHK("overrun_flag", 1'b1, v[2])
        wr(4'h4, 32'h4);
        {self_test, online} <= 2'b01;
        repeat (4) @(posedge aclk);
        `CHK("dtr_online", 1'b1, dtr)
        online <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK("dtr_free", 1'b0, dtr)
    endtask
    task automatic t_status;
        int k;
        dsr <= 1'b1;
        k = n_got;
        wr(4'h8, 32'h5a);
        repeat (bit_cyc * 20) @(posedge aclk);
        `CHK("tx_held", k, n_got)
        dsr <= 1'b0;
        waittx(k);
        `CHK("tx_byte", 8'h5a, got)
        cfg(EN | 32'h28);
        dsr <= 1'b1;
        k = n_got;
        wr(4'h8, 32'ha3);
        waittx(k);
        `CHK("tx_nodsr", 8'ha3, got)
        dsr <= 1'b0;
    endtask
    task automatic t_flow;
        int k;
        k = n_got;
        for (int i = 0; i < 63; i++) i_host.send(8'h40 + i[7:0], 0, 0, 0, 0, 0, 0);
        waittx(k);
        `CHK("xoff", 8'h13, got)
        rd(4'hc, v);
        `CHK("free_low", 13'd10, v[12:0])
        k = n_got;
        for (int i = 0; i < 11; i++) take(8'h40 + i[7:0]);
        waittx(k);
        `CHK("xon", 8'h11, got)
        for (int i = 11; i < 63; i++) take(8'h40 + i[7:0]);
        cfg(EN | 32'h128);
        rd(4'hc, v);
        `CHK("free_large", 13'h1000, v[12:0])
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // cut a hang short
    initial begin
        repeat (95000) @(posedge aclk);
        error_cnt++;
        end_of_test;
    end
    // reset, then the scenarios in turn
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, dsr, self_test, online} = 9'h0;
        {oready, xon, awaddr, araddr, wdata} = 42'h0;
        bit_cyc = 16'd80;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_rates;
        t_parity;
        t_frame;
        t_busy;
        t_status;
        t_flow;
        end_of_test;
    end
endmodule
